/* hdl/op_sequencer.sv */
// Purpose: sequencer end: turns register writes into panel commands
// Assumes: software port with read data one cycle after the read strobe
// Notes:   illegal or out-of-order commands are refused and flag an error
`timescale 1ns/1ps
`include "simd_ops_map.svh"

module op_sequencer
(
    input  wire logic              mclk_i,
    input  wire logic              srst_i,
    input  wire logic [7:0]        addr_i,
    input  wire logic [31:0]       wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [31:0]       rdata_o,
    panel_link_if.seq              link
);
    import simd_ops_pkg::*;

    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_wait = 2'b10
    } seq_state_e;

    seq_state_e  state;
    cmd_s        ops;
    logic        cmd_valid;
    cmd_s        cmd;
    logic        err;
    logic [2:0]  chain;
    logic [7:0]  next_dst;

    // length limits per command
    function automatic logic len_ok(input op_e op, input logic [5:0] len,
                                    input logic [2:0] slen, input logic [3:0] n);
        logic r;
        r = 1'b1;
        unique case (op)
            op_first_edge_test, op_middle_edge_test, op_depth_compare,
            op_first_span_load, op_middle_span_load:
                r = len >= 6'd2 && len <= 6'd4;
            op_last_span_load, op_table_step:
                r = len >= 6'd1 && len <= 6'd4;
            op_table_entry:
                r = 6'(slen) + len <= 6'd4 && slen != 3'd0;
            op_neighbour_swap:
                r = len >= 6'd1 && len <= 6'd32 && n >= 4'd1 && n <= 4'd7;
            op_copy_from_higher, op_copy_from_lower:
                r = len >= 6'd1 && len <= 6'd32
                    && (n == 4'd1 || n == 4'd2 || n == 4'd4 || n == 4'd8);
            default:
                r = 1'b1;
        endcase
        return r;
    endfunction

    wire logic       launch_req = wr_i && addr_i == `REG_CMD;
    wire op_e        req_op     = op_e'(wdata_i[`CMD_OP_LSB +: 5]);
    wire logic       span_mid   = req_op == op_middle_span_load
                                  || req_op == op_single_byte_load
                                  || req_op == op_last_span_load;
    wire logic [5:0] req_len    = (req_op == op_single_byte_load) ? 6'd1 : ops.len;
    // chain: 0 none, 1 first edge, 2 middle edge, 3 depth, 4 loads under way
    wire logic       order_ok   =
        (req_op == op_middle_edge_test) ? (chain == 3'd1 || chain == 3'd2) :
        (req_op == op_depth_compare)    ? chain == 3'd2 :
        (req_op == op_first_span_load)  ? chain == 3'd3 :
        span_mid                        ? (chain == 3'd4 && ops.dst == next_dst) :
        1'b1;
    wire logic       legal      = order_ok && len_ok(req_op, req_len, ops.slen, ops.n);
    wire logic       accept     = launch_req && state == st_idle && legal;
    wire logic       refuse     = launch_req && !accept;
    wire logic       err_clear  = wr_i && addr_i == `REG_STATUS && wdata_i[`STAT_ERR_BIT];

    assign link.cmd_valid = cmd_valid;
    assign link.cmd       = cmd;

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            state     <= st_idle;
            ops       <= '0;
            cmd       <= '0;
            cmd_valid <= 1'b0;
            err       <= 1'b0;
            chain     <= 3'd0;
            next_dst  <= 8'h00;
            rdata_o   <= 32'h00000000;
        end
        else
        begin
            cmd_valid <= accept;
            err       <= refuse | (err & ~err_clear);
            if (wr_i)
            begin
                unique case (addr_i)
                    `REG_OPS:
                    begin
                        ops.dst  <= wdata_i[`OPS_DST_LSB +: 8];
                        ops.src  <= wdata_i[`OPS_SRC_LSB +: 8];
                        ops.len  <= wdata_i[`OPS_LEN_LSB +: 6];
                        ops.slen <= wdata_i[`OPS_SLEN_LSB +: 3];
                        ops.n    <= wdata_i[`OPS_N_LSB +: 4];
                    end
                    `REG_COEF_A: ops.a <= wdata_i[15:0];
                    `REG_COEF_B: ops.b <= wdata_i[15:0];
                    `REG_COEF_C: ops.c <= wdata_i;
                    default:     ops.op <= ops.op;
                endcase
            end
            if (accept)
            begin
                cmd        <= ops;
                cmd.op     <= req_op;
                cmd.linear <= wdata_i[`CMD_LINEAR_BIT];
                cmd.len    <= req_len;
                unique case (req_op)
                    op_first_edge_test:  chain <= 3'd1;
                    op_middle_edge_test: chain <= 3'd2;
                    op_depth_compare:    chain <= 3'd3;
                    op_first_span_load, op_middle_span_load, op_single_byte_load:
                        chain <= 3'd4;
                    op_table_step, op_memory_to_scratch, op_last_span_load:
                        chain <= 3'd0;
                    default:             chain <= chain;
                endcase
                next_dst <= 8'(ops.dst + 8'(req_len) - 8'h01);
                if (req_op == op_first_span_load || span_mid)
                    next_dst <= 8'(ops.dst + 8'(req_len));
            end
            unique case (state)
                st_idle: if (accept) state <= st_wait;
                st_wait: if (link.done) state <= st_idle;
            endcase
            rdata_o <= 32'h00000000;
            if (rd_i)
            begin
                unique case (addr_i)
                    `REG_OPS:    rdata_o <= {3'h0, ops.n, ops.slen, ops.len, ops.src, ops.dst};
                    `REG_COEF_A: rdata_o <= {16'h0000, ops.a};
                    `REG_COEF_B: rdata_o <= {16'h0000, ops.b};
                    `REG_COEF_C: rdata_o <= ops.c;
                    `REG_STATUS: rdata_o <= {30'h0, err, state == st_wait};
                    `REG_ENABLE: rdata_o <= link.en_vec;
                    `REG_CARRY:  rdata_o <= link.cry_vec;
                    default:     rdata_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

/* hdl/panel_link_if.sv */
// Purpose: command link between the sequencer and one 32-element panel
// Assumes: both ends on mclk_i
// Notes:   one command per valid pulse, done pulses once per command
`timescale 1ns/1ps

interface panel_link_if;
    import simd_ops_pkg::*;

    logic      cmd_valid;
    cmd_s      cmd;
    logic      done;
    flag_vec_t en_vec;
    flag_vec_t cry_vec;

    modport dev
    (
        input  cmd_valid,
        input  cmd,
        output done,
        output en_vec,
        output cry_vec
    );

    modport seq
    (
        output cmd_valid,
        output cmd,
        input  done,
        input  en_vec,
        input  cry_vec
    );
endinterface

/* hdl/pixel_panel.sv */
// Purpose: one panel of 32 processing elements running special render commands
// Assumes: commands arrive from the sequencer end on the same clock
// Notes:   a command is latched, executed in the next cycle, done pulses as its results land
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "simd_ops_map.svh"

module pixel_panel
(
    input  wire logic              mclk_i,
    input  wire logic              srst_i,
    panel_link_if.dev              link,
    input  wire logic [4:0]        peek_elem_i,
    input  wire logic [7:0]        peek_addr_i,
    output logic      [7:0]        peek_data_o
);
    import simd_ops_pkg::*;

    localparam int NPE = `PANEL_SIZE;
    localparam int NMB = `MEM_BYTES;

    logic [7:0]  mem [NPE][NMB];
    logic [7:0]  scratch [NPE];
    flag_vec_t   en;
    flag_vec_t   cry;
    logic [7:0]  base;
    logic [15:0] xoff;
    logic [15:0] yoff;
    logic        pend;
    cmd_s        cur;
    logic        done;
    logic [31:0] tree [NPE];

    function automatic logic [5:0] phys(input logic [7:0] b, input logic [7:0] a,
                                        input int k);
        logic [7:0] s;
        s = 8'(b + a + 8'(k));
        return s[5:0];
    endfunction

    function automatic logic [7:0] tbyte(input logic [31:0] v, input int k);
        logic [7:0] r;
        r = {8{v[31]}};
        if (k < `TREE_BYTES)
            r = v[8*k +: 8];
        return r;
    endfunction

    function automatic logic sign_of(input logic [31:0] v, input logic [5:0] len);
        logic r;
        r = v[31];
        unique case (len)
            6'h01: r = v[7];
            6'h02: r = v[15];
            6'h03: r = v[23];
            default: r = v[31];
        endcase
        return r;
    endfunction

    // low len bytes of a value, upper bytes cleared
    function automatic logic [31:0] low_bytes(input logic [31:0] v, input logic [5:0] len);
        logic [31:0] r;
        r = v;
        unique case (len)
            6'h01: r = {24'h000000, v[7:0]};
            6'h02: r = {16'h0000, v[15:0]};
            6'h03: r = {8'h00, v[23:0]};
            default: r = v;
        endcase
        return r;
    endfunction

    function automatic logic [31:0] mem_word(input int i, input logic [7:0] a,
                                             input logic [5:0] len);
        logic [31:0] r;
        r = 32'h00000000;
        for (int k = 0; k < `TREE_BYTES; k++)
            r[8*k +: 8] = mem[i][phys(base, a, k)];
        return low_bytes(r, len);
    endfunction

    // per-element linear expression from panel coordinates
    always_comb
    begin
        for (int i = 0; i < NPE; i++)
        begin
            logic [15:0] x;
            logic [15:0] y;
            x = 16'(xoff + 16'(i % 8));
            y = 16'(yoff + 16'(i / 8));
            if (cur.linear)
                tree[i] = 32'($signed(cur.a) * $signed({16'h0000, x}))
                        + 32'($signed(cur.b) * $signed({16'h0000, y}))
                        + cur.c;
            else
                tree[i] = cur.c;
        end
    end

    wire logic [7:0] peek_byte = mem[peek_elem_i][phys(base, peek_addr_i, 0)];

    assign link.done    = done;
    assign link.en_vec  = en;
    assign link.cry_vec = cry;

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            pend        <= 1'b0;
            done        <= 1'b0;
            en          <= `RST_ENABLE;
            cry         <= `RST_CARRY;
            base        <= 8'h00;
            xoff        <= 16'h0000;
            yoff        <= 16'h0000;
            peek_data_o <= 8'h00;
            for (int i = 0; i < NPE; i++)
                scratch[i] <= 8'h00;
        end
        else
        begin
            pend        <= link.cmd_valid;
            cur         <= link.cmd;
            done        <= pend;
            peek_data_o <= peek_byte;
            if (pend)
            begin
                unique case (cur.op)
                    op_memory_base_set:
                        base <= cur.dst;
                    op_region_offset_set:
                    begin
                        xoff <= cur.c[15:0];
                        yoff <= cur.c[31:16];
                    end
                    op_region_sample:
                    begin
                        base <= cur.dst;
                        xoff <= cur.c[15:0];
                        yoff <= cur.c[31:16];
                    end
                    default:
                        base <= base;
                endcase
                // flags and scratch change only in the cases below
                for (int i = 0; i < NPE; i++)
                begin
                    unique case (cur.op)
                        op_first_edge_test:
                        begin
                            en[i]  <= 1'b1;
                            cry[i] <= sign_of(tree[i], cur.len);
                        end
                        op_middle_edge_test:
                        begin
                            en[i]  <= en[i] & ~cry[i];
                            cry[i] <= sign_of(tree[i], cur.len);
                        end
                        op_depth_compare:
                        begin
                            en[i]  <= en[i] & ~cry[i];
                            cry[i] <= mem_word(i, cur.src, cur.len)
                                      >= low_bytes(tree[i], cur.len);
                        end
                        op_first_span_load:
                        begin
                            en[i] <= en[i] & cry[i];
                            if (en[i] & cry[i])
                            begin
                                for (int k = 0; k < `TREE_BYTES - 1; k++)
                                    if (k < int'(cur.len) - 1)
                                        mem[i][phys(base, cur.dst, k)] <= tbyte(tree[i], k);
                                scratch[i] <= tbyte(tree[i], int'(cur.len) - 1);
                            end
                        end
                        op_middle_span_load, op_single_byte_load:
                        begin
                            if (en[i])
                            begin
                                mem[i][phys(base, cur.dst, -1)] <= scratch[i];
                                for (int k = 0; k < `TREE_BYTES - 1; k++)
                                    if (k < int'(cur.len) - 1)
                                        mem[i][phys(base, cur.dst, k)] <= tbyte(tree[i], k);
                                scratch[i] <= tbyte(tree[i], int'(cur.len) - 1);
                            end
                        end
                        op_last_span_load:
                        begin
                            if (en[i])
                            begin
                                mem[i][phys(base, cur.dst, -1)] <= scratch[i];
                                for (int k = 0; k < `TREE_BYTES; k++)
                                    if (k < int'(cur.len))
                                        mem[i][phys(base, cur.dst, k)] <= tbyte(tree[i], k);
                            end
                        end
                        op_table_step:
                        begin
                            if (en[i])
                                for (int k = 0; k < `TREE_BYTES; k++)
                                    if (k < int'(cur.len))
                                        mem[i][phys(base, cur.dst, k)] <= tbyte(tree[i], k);
                            en[i]      <= en[i] & (scratch[i] != 8'h00);
                            scratch[i] <= 8'(scratch[i] - 8'h01);
                        end
                        op_table_entry:
                        begin
                            if (en[i] && mem_word(i, cur.src, 6'(cur.slen))
                                         == low_bytes(tree[i], 6'(cur.slen)))
                                for (int k = 0; k < `TREE_BYTES; k++)
                                    if (k < int'(cur.len))
                                        mem[i][phys(base, cur.dst, k)]
                                            <= tbyte(tree[i], k + int'(cur.slen));
                        end
                        op_memory_to_scratch:
                        begin
                            if (en[i])
                                scratch[i] <= mem[i][phys(base, cur.src, 0)];
                        end
                        op_neighbour_swap:
                        begin
                            // carry marks the lower operand, enable the upper one
                            for (int k = 0; k < `MAX_XFER_LEN; k++)
                                if (k < int'(cur.len))
                                begin
                                    if (cry[i] && i + int'(cur.n) < NPE
                                        && en[i + int'(cur.n)])
                                        mem[i][phys(base, cur.src, k)]
                                            <= mem[i + int'(cur.n)][phys(base, cur.dst, k)];
                                    if (en[i] && i - int'(cur.n) >= 0
                                        && cry[i - int'(cur.n)])
                                        mem[i][phys(base, cur.dst, k)]
                                            <= mem[i - int'(cur.n)][phys(base, cur.src, k)];
                                end
                        end
                        op_copy_from_higher, op_copy_from_lower:
                        begin
                            int j;
                            j = (cur.op == op_copy_from_higher) ? i + int'(cur.n)
                                                                : i - int'(cur.n);
                            if (en[i])
                                for (int k = 0; k < `MAX_XFER_LEN; k++)
                                    if (k < int'(cur.len))
                                        mem[i][phys(base, cur.dst, k)]
                                            <= (j >= 0 && j < NPE)
                                               ? mem[j][phys(base, cur.src, k)]
                                               : 8'h00;
                        end
                        default:
                            scratch[i] <= scratch[i];
                    endcase
                end
            end
        end
    end
endmodule

/* hdl/simd_ops_map.svh */
// Purpose: constants shared by the panel datapath and its command sequencer
// Assumes: byte addressed register port, 32-bit data
// Notes:   offsets are byte addresses of the sequencer's own registers
`ifndef SIMD_OPS_MAP_SVH
`define SIMD_OPS_MAP_SVH

`define PANEL_SIZE     32
`define MEM_BYTES      64
`define TREE_BYTES     4
`define MAX_XFER_LEN   32

`define REG_CMD        8'h00
`define REG_OPS        8'h04
`define REG_COEF_A     8'h08
`define REG_COEF_B     8'h0c
`define REG_COEF_C     8'h10
`define REG_STATUS     8'h14
`define REG_ENABLE     8'h18
`define REG_CARRY      8'h1c

`define CMD_OP_LSB     0
`define CMD_LINEAR_BIT 8
`define OPS_DST_LSB    0
`define OPS_SRC_LSB    8
`define OPS_LEN_LSB    16
`define OPS_SLEN_LSB   22
`define OPS_N_LSB      25
`define STAT_BUSY_BIT  0
`define STAT_ERR_BIT   1

`define RST_ENABLE     32'hffffffff
`define RST_CARRY      32'h00000000

`endif

/* hdl/simd_ops_pkg.sv */
// Purpose: types shared by the panel datapath and its command sequencer
// Assumes: constants from simd_ops_map.svh
// Notes:   one command word carries every operand of any command
`include "simd_ops_map.svh"

package simd_ops_pkg;

    typedef enum logic [4:0] {
        op_nop                = 5'h00,
        op_first_edge_test    = 5'h01,
        op_middle_edge_test   = 5'h02,
        op_depth_compare      = 5'h03,
        op_first_span_load    = 5'h04,
        op_middle_span_load   = 5'h05,
        op_single_byte_load   = 5'h06,
        op_last_span_load     = 5'h07,
        op_table_step         = 5'h08,
        op_table_entry        = 5'h09,
        op_region_sample      = 5'h0a,
        op_memory_base_set    = 5'h0b,
        op_region_offset_set  = 5'h0c,
        op_memory_to_scratch  = 5'h0d,
        op_neighbour_swap     = 5'h0e,
        op_copy_from_higher   = 5'h0f,
        op_copy_from_lower    = 5'h10
    } op_e;

    typedef struct packed {
        op_e         op;
        logic        linear;
        logic [7:0]  dst;
        logic [7:0]  src;
        logic [5:0]  len;
        logic [2:0]  slen;
        logic [3:0]  n;
        logic [15:0] a;
        logic [15:0] b;
        logic [31:0] c;
    } cmd_s;

    typedef logic [`PANEL_SIZE-1:0] flag_vec_t;

endpackage

/* sim/simd_link_properties.sv */
// Purpose: link checks between the sequencer end and the panel end
// Assumes: one clock, synchronous reset, commands spaced by done
// Notes:   flag effects of a command land two cycles after cmd_valid
`timescale 1ns/1ps
module simd_link_properties
(
    input wire logic                    mclk_i,
    input wire logic                    srst_i,
    input wire logic                    cmd_valid,
    input wire simd_ops_pkg::cmd_s      cmd,
    input wire logic                    done,
    input wire simd_ops_pkg::flag_vec_t en_vec,
    input wire simd_ops_pkg::flag_vec_t cry_vec
);
    import simd_ops_pkg::*;
    op_e op;
    assign op = cmd.op;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    a_done_delay: assert property (cmd_valid |-> !done ##1 !done ##1 done)
        else $error("done not two cycles after command");
    a_done_cause: assert property (done |-> $past(cmd_valid, 2))
        else $error("done without a command");
    a_first_enable: assert property (cmd_valid && op == op_first_edge_test
        |-> ##2 en_vec == '1) else $error("first edge left an element disabled");
    a_middle_gate: assert property (cmd_valid && op == op_middle_edge_test
        |-> ##2 en_vec == ($past(en_vec, 2) & ~$past(cry_vec, 2)))
        else $error("middle edge enable");
    a_depth_gate: assert property (cmd_valid && op == op_depth_compare
        |-> ##2 en_vec == ($past(en_vec, 2) & ~$past(cry_vec, 2))) else $error("depth enable");
    a_load_gate: assert property (cmd_valid && op == op_first_span_load
        |-> ##2 en_vec == ($past(en_vec, 2) & $past(cry_vec, 2))) else $error("first load enable");
    a_step_narrow: assert property (cmd_valid && op == op_table_step
        |-> ##2 (en_vec & ~$past(en_vec, 2)) == '0) else $error("table step raised an enable");
    a_entry_keep: assert property (cmd_valid && op == op_table_entry
        |-> ##2 en_vec == $past(en_vec, 2)) else $error("table entry changed enable");
    a_xfer_flags: assert property (cmd_valid
        && op inside {op_neighbour_swap, op_copy_from_higher, op_copy_from_lower}
        |-> ##2 en_vec == $past(en_vec, 2) && cry_vec == $past(cry_vec, 2))
        else $error("transfer changed flags");
    a_flags_hold: assert property (!done |-> $stable(en_vec) && $stable(cry_vec))
        else $error("flags moved without a command");
    c_first: cover property (cmd_valid && op == op_first_edge_test);
    c_swap: cover property (cmd_valid && op == op_neighbour_swap);
    c_copy: cover property (cmd_valid && op == op_copy_from_higher);
endmodule

/* sim/testbench.sv */
// Purpose: drives the sequencer register port and checks panel results
// Assumes: sequencer and panel joined by one link interface
// Notes:   expected reads and peeks are queued and checked by a monitor
`timescale 1ns/1ps
`include "simd_ops_map.svh"
module testbench;
    import simd_ops_pkg::*;
    logic        mclk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic        pk_r = 1'b0, rd_d = 1'b0, pk_d = 1'b0;
    logic [7:0]  addr_i = 8'h00, peek_addr_i = 8'h00, peek_data_o;
    logic [4:0]  peek_elem_i = 5'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o, k, v, w, cyc = 32'h0;
    flag_vec_t   xm, ym;
    int          errors = 0, check_count = 0;
    logic [31:0] rq[$], pq[$];
    string       rn[$], pn[$];
    panel_link_if lnk();
    op_sequencer op_sequencer_inst (.mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(lnk));
    pixel_panel pixel_panel_inst (.mclk_i(mclk_i), .srst_i(srst_i), .link(lnk),
        .peek_elem_i(peek_elem_i), .peek_addr_i(peek_addr_i), .peek_data_o(peek_data_o));
    simd_link_properties simd_link_properties_inst (.mclk_i(mclk_i), .srst_i(srst_i),
        .cmd_valid(lnk.cmd_valid), .cmd(lnk.cmd), .done(lnk.done), .en_vec(lnk.en_vec),
        .cry_vec(lnk.cry_vec));
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp(nm, {24'h0, e}, {24'h0, g});
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        rq.push_back(e);
        rn.push_back(nm);
        @(posedge mclk_i);
        rd_i <= 1'b0;
    endtask
    task automatic pk(input logic [4:0] el, input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        peek_elem_i <= el;
        peek_addr_i <= a;
        pk_r <= 1'b1;
        pq.push_back({24'h0, e});
        pn.push_back("peek");
        @(posedge mclk_i);
        pk_r <= 1'b0;
    endtask
    function automatic logic [31:0] ops(input logic [7:0] d, input logic [7:0] s,
        input logic [5:0] l, input logic [2:0] sl, input logic [3:0] n);
        return {3'h0, n, sl, l, s, d};
    endfunction
    task automatic run(input op_e op, input logic lin, input logic [31:0] o,
        input logic [15:0] a, input logic [15:0] b, input logic [31:0] c);
        wr(`REG_OPS, o);
        wr(`REG_COEF_A, {16'h0, a});
        wr(`REG_COEF_B, {16'h0, b});
        wr(`REG_COEF_C, c);
        wr(`REG_CMD, {23'h0, lin, 3'h0, op});
        for (int i = 0; i < 20 && lnk.done !== 1'b1; i++)
            @(negedge mclk_i);
        repeat (2) @(posedge mclk_i);
    endtask
    initial
    begin
        forever #50 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i)
    begin
        rd_d <= rd_i;
        pk_d <= pk_r;
        cyc <= cyc + 32'h1;
        if (rd_d)
            cmp(rn.pop_front(), rq.pop_front(), rdata_o);
        if (pk_d)
            cmp8(pn.pop_front(), pq[0][7:0], peek_data_o);
        if (pk_d)
            void'(pq.pop_front());
        if (cyc > 32'd5000)
        begin
            errors++;
            end_of_test();
        end
    end
    initial
    begin
        void'($urandom(32'hd9710fb0));
        k = $urandom | 32'h1;
        v = $urandom;
        w = $urandom;
        for (int i = 0; i < 32; i++)
        begin
            xm[i] = (i % 8) < 4;
            ym[i] = (i / 8) < 2;
        end
        repeat (6) @(posedge mclk_i);
        srst_i <= 1'b0;
        run(op_table_step, 1'b0, ops(8'd0, 8'd0, 6'd4, 3'd0, 4'd0), 16'h0, 16'h0, k);
        rd(`REG_ENABLE, 32'h0, "enable");
        pk(5'd5, 8'd3, k[31:24]);
        rd(8'h20, 32'h0, "unmapped");
        $display("test table_step done");
        run(op_first_edge_test, 1'b1, ops(8'd0, 8'd0, 6'd4, 3'd0, 4'd0), 16'h1, '0, 32'hfffffffc);
        rd(`REG_ENABLE, '1, "enable");
        rd(`REG_CARRY, xm, "carry");
        run(op_middle_edge_test, 1'b1, ops(8'd0, 8'd0, 6'd4, 3'd0, 4'd0), '0, 16'h1, 32'hfffffffe);
        rd(`REG_ENABLE, ~xm, "enable");
        rd(`REG_CARRY, ym, "carry");
        run(op_depth_compare, 1'b0, ops(8'd0, 8'd0, 6'd2, 3'd0, 4'd0), '0, '0, {17'h0, k[15:1]});
        rd(`REG_ENABLE, ~xm & ~ym, "enable");
        rd(`REG_CARRY, '1, "carry");
        run(op_first_span_load, 1'b0, ops(8'd8, 8'd0, 6'd2, 3'd0, 4'd0), 16'h0, 16'h0, v);
        run(op_last_span_load, 1'b0, ops(8'd10, 8'd0, 6'd1, 3'd0, 4'd0), 16'h0, 16'h0, w);
        pk(5'd31, 8'd8, v[7:0]);
        pk(5'd31, 8'd9, v[15:8]);
        pk(5'd31, 8'd10, w[7:0]);
        $display("test edge_and_span done");
        run(op_first_edge_test, 1'b0, ops(8'd0, 8'd0, 6'd4, 3'd0, 4'd0), 16'h0, 16'h0, '1);
        run(op_copy_from_higher, 1'b0, ops(8'd16, 8'd0, 6'd1, 3'd0, 4'd8), 16'h0, 16'h0, 32'h0);
        pk(5'd23, 8'd16, k[7:0]);
        pk(5'd24, 8'd16, 8'h00);
        run(op_table_entry, 1'b0, ops(8'd20, 8'd16, 6'd1, 3'd1, 4'd0), 16'h0, 16'h0,
            {16'h0, v[7:0], k[7:0]});
        pk(5'd0, 8'd20, v[7:0]);
        run(op_copy_from_lower, 1'b0, ops(8'd21, 8'd0, 6'd1, 3'd0, 4'd4), '0, '0, '0);
        pk(5'd4, 8'd21, k[7:0]);
        pk(5'd3, 8'd21, 8'h00);
        run(op_neighbour_swap, 1'b0, ops(8'd17, 8'd16, 6'd1, 3'd0, 4'd1), '0, '0, '0);
        rd(`REG_CARRY, '1, "carry");
        run(op_middle_span_load, 1'b0, ops(8'd0, 8'd0, 6'd2, 3'd0, 4'd0), '0, '0, '0);
        rd(`REG_STATUS, 32'h2, "status");
        wr(`REG_STATUS, 32'h2);
        rd(`REG_STATUS, 32'h0, "status");
        $display("test panel_transfer done");
        repeat (3) @(posedge mclk_i);
        end_of_test();
    end
endmodule
